// ### inc/fcc_params.svh
// Constants of the four-channel capture/compare timer control block.
// Assumes an 8-bit register port with registers at their byte offsets.
//
// How it works
// - Overflow toggles pin when toggle bit set
// - Overflow toggle only in compare mode
// - Overflow toggle beats coinciding compare action
// - Mode/level pair picks compare pin action
// - Nonzero mode/level makes pin an output
// - Edge bits pick capture edge or disable
// - Channel request while flag and enable set
// - Overflow request while flag and enable set
// - Channel 3 compare resets counter if enabled
// - Zero ch3 value keeps counter at zero
// - All-ones ch3 reset sets no overflow
// - Prescaler divides clock by two to select
// - New prescale applies when stages all zero
// - Timer runs only while global enable set
// - Sixteen-bit counter counts up per tick
// - Wrap sets overflow flag, one clears
// - Event sets channel flag, one clears
`ifndef FCC_PARAMS_SVH
`define FCC_PARAMS_SVH

`define FCC_ADDR_W 8
`define FCC_DATA_W 8
`define FCC_CH_N 4
`define FCC_CNT_W 16
`define FCC_PSC_W 7
`define FCC_REG_RESET 8'h00
`define FCC_CNT_RESET 16'h0000
`define FCC_CNT_MAX 16'hffff

`define FCC_OFS_MODE 8'hc0
`define FCC_OFS_CNT_HI 8'hc4
`define FCC_OFS_CNT_LO 8'hc5
`define FCC_OFS_ENABLE 8'hc6
`define FCC_OFS_TOGGLE 8'hc7
`define FCC_OFS_ACTION 8'hc8
`define FCC_OFS_EDGE 8'hc9
`define FCC_OFS_IRQEN 8'hca
`define FCC_OFS_SC2 8'hcb
`define FCC_OFS_CHFLG 8'hcc
`define FCC_OFS_OVFLG 8'hcd
`define FCC_OFS_VAL_FIRST 8'hce
`define FCC_OFS_VAL_LAST 8'hd5

`define FCC_BIT_ENABLE 7
`define FCC_BIT_OVIRQ 7
`define FCC_BIT_CNTRST 3
`define FCC_BIT_OVFLAG 7
`define FCC_PSC_LSB 0
`define FCC_PSC_MSB 2

`endif

// ### inc/fcc_pkg.sv
// Types of the four-channel capture/compare timer control block.
// Assumes fcc_params.svh is on the include path.
`include "fcc_params.svh"
package fcc_pkg;
  typedef struct packed {
    logic [`FCC_ADDR_W-1:0] addr;
    logic [`FCC_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } fcc_bus_req_t;

  typedef enum logic [1:0] {
    FCC_EDGE_OFF = 2'b00,
    FCC_EDGE_RISE = 2'b01,
    FCC_EDGE_FALL = 2'b10,
    FCC_EDGE_ANY = 2'b11
  } fcc_edge_t;

  typedef enum logic [1:0] {
    FCC_ACT_NONE = 2'b00,
    FCC_ACT_TOGGLE = 2'b01,
    FCC_ACT_LOW = 2'b10,
    FCC_ACT_HIGH = 2'b11
  } fcc_action_t;
endpackage

// ### hdl/fcc_channel.sv
// One timer channel: capture input synchroniser and edge detector,
// compare output pin logic. Assumes single clock, events from the top.
`timescale 1ns/100ps
module fcc_channel (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pinIn,
  input wire fcc_pkg::fcc_edge_t edgeSel,
  input wire logic compareMode,
  input wire fcc_pkg::fcc_action_t action,
  input wire logic toggleOnOvf,
  input wire logic ovfEvt,
  input wire logic cmpEvt,
  output logic captureEvt,
  output logic pinOut,
  output logic pinOe
);
  import fcc_pkg::*;

  logic sync1_ff, sync2_ff, sync3_ff, level_ff;
  logic rise, fall;

  ////////////////////////////////////////////////////////////////////////
  // Input synchroniser and filtered level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end else begin
      sync1_ff <= pinIn;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_ff <= 1'b0;
    end else if (sync2_ff == sync3_ff) begin
      level_ff <= sync3_ff;
    end
  end

  assign rise = (sync2_ff == sync3_ff) && sync3_ff && !level_ff;
  assign fall = (sync2_ff == sync3_ff) && !sync3_ff && level_ff;

  always_comb begin
    captureEvt = 1'b0;
    if (!compareMode) begin
      unique case (edgeSel)
        FCC_EDGE_OFF: captureEvt = 1'b0;
        FCC_EDGE_RISE: captureEvt = rise;
        FCC_EDGE_FALL: captureEvt = fall;
        FCC_EDGE_ANY: captureEvt = rise | fall;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare output pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut <= 1'b0;
    end else if (compareMode && toggleOnOvf && ovfEvt) begin
      pinOut <= !pinOut;
    end else if (compareMode && cmpEvt) begin
      unique case (action)
        FCC_ACT_NONE: pinOut <= pinOut;
        FCC_ACT_TOGGLE: pinOut <= !pinOut;
        FCC_ACT_LOW: pinOut <= 1'b0;
        FCC_ACT_HIGH: pinOut <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOe <= 1'b0;
    end else begin
      pinOe <= (action != FCC_ACT_NONE);
    end
  end
endmodule

// ### hdl/fcc_timer.sv
// Four-channel capture/compare timer: registers, prescaler, counter,
// flags and interrupt requests. Assumes the plain register port master
// and asynchronous capture pins.
`timescale 1ns/100ps
`include "fcc_params.svh"
module fcc_timer #(
  parameter int CH_N = `FCC_CH_N,
  parameter int CNT_W = `FCC_CNT_W,
  parameter int PSC_W = `FCC_PSC_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire fcc_pkg::fcc_bus_req_t busReq,
  output logic [`FCC_DATA_W-1:0] rdData,
  input wire logic [CH_N-1:0] pinIn,
  output logic [CH_N-1:0] pinOut,
  output logic [CH_N-1:0] pinOe,
  output logic [CH_N-1:0] chIrq,
  output logic ovfIrq,
  output logic [CNT_W-1:0] timerCount
);
  import fcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Control registers
  logic [CH_N-1:0] compareMode_ff;
  logic timerEnable_ff;
  logic [CH_N-1:0] ovfToggle_ff;
  logic [2*CH_N-1:0] outAction_ff;
  logic [2*CH_N-1:0] edgeSel_ff;
  logic [CH_N-1:0] chIrqEn_ff;
  logic ovfIrqEn_ff;
  logic cntReset_ff;
  logic [2:0] pscSel_ff;
  logic [2:0] pscActive_ff;
  logic [PSC_W-1:0] pscCnt_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CH_N-1:0] chFlag_ff;
  logic ovfFlag_ff;
  logic [CNT_W-1:0] value_ff [CH_N];
  logic [`FCC_DATA_W-1:0] nxt_rdData;

  logic wrMode, wrEnable, wrToggle, wrAction, wrEdge, wrIrqEn, wrSc2;
  logic wrCntHi, wrCntLo, wrChFlg, wrOvFlg, wrVal;
  logic [7:0] valOfs;
  logic [1:0] valIdx;
  logic valHigh;
  logic [PSC_W-1:0] pscMask;
  logic tick;
  logic [CH_N-1:0] cmpEvt, capEvt;
  logic ch3Reset, ovfEvt;

  assign wrMode = busReq.wr && (busReq.addr == `FCC_OFS_MODE);
  assign wrEnable = busReq.wr && (busReq.addr == `FCC_OFS_ENABLE);
  assign wrToggle = busReq.wr && (busReq.addr == `FCC_OFS_TOGGLE);
  assign wrAction = busReq.wr && (busReq.addr == `FCC_OFS_ACTION);
  assign wrEdge = busReq.wr && (busReq.addr == `FCC_OFS_EDGE);
  assign wrIrqEn = busReq.wr && (busReq.addr == `FCC_OFS_IRQEN);
  assign wrSc2 = busReq.wr && (busReq.addr == `FCC_OFS_SC2);
  assign wrCntHi = busReq.wr && (busReq.addr == `FCC_OFS_CNT_HI);
  assign wrCntLo = busReq.wr && (busReq.addr == `FCC_OFS_CNT_LO);
  assign wrChFlg = busReq.wr && (busReq.addr == `FCC_OFS_CHFLG);
  assign wrOvFlg = busReq.wr && (busReq.addr == `FCC_OFS_OVFLG);
  assign wrVal = busReq.wr && (busReq.addr >= `FCC_OFS_VAL_FIRST)
                 && (busReq.addr <= `FCC_OFS_VAL_LAST);
  assign valOfs = busReq.addr - `FCC_OFS_VAL_FIRST;
  assign valIdx = valOfs[2:1];
  assign valHigh = !valOfs[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compareMode_ff <= '0;
    end else if (wrMode) begin
      compareMode_ff <= busReq.wdata[CH_N-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timerEnable_ff <= 1'b0;
    end else if (wrEnable) begin
      timerEnable_ff <= busReq.wdata[`FCC_BIT_ENABLE];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovfToggle_ff <= '0;
    end else if (wrToggle) begin
      ovfToggle_ff <= busReq.wdata[CH_N-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outAction_ff <= '0;
    end else if (wrAction) begin
      outAction_ff <= busReq.wdata[2*CH_N-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edgeSel_ff <= '0;
    end else if (wrEdge) begin
      edgeSel_ff <= busReq.wdata[2*CH_N-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chIrqEn_ff <= '0;
    end else if (wrIrqEn) begin
      chIrqEn_ff <= busReq.wdata[CH_N-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovfIrqEn_ff <= 1'b0;
      cntReset_ff <= 1'b0;
      pscSel_ff <= '0;
    end else if (wrSc2) begin
      ovfIrqEn_ff <= busReq.wdata[`FCC_BIT_OVIRQ];
      cntReset_ff <= busReq.wdata[`FCC_BIT_CNTRST];
      pscSel_ff <= busReq.wdata[`FCC_PSC_MSB:`FCC_PSC_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescaler
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pscCnt_ff <= '0;
    end else if (timerEnable_ff) begin
      pscCnt_ff <= pscCnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pscActive_ff <= '0;
    end else if (pscCnt_ff == '0) begin
      pscActive_ff <= pscSel_ff;
    end
  end

  assign pscMask = PSC_W'((1 << pscActive_ff) - 1);
  assign tick = timerEnable_ff && ((pscCnt_ff & pscMask) == pscMask);

  ////////////////////////////////////////////////////////////////////////
  // Main counter
  always_comb begin
    for (int i = 0; i < CH_N; i++) begin
      cmpEvt[i] = tick && compareMode_ff[i] && (cnt_ff == value_ff[i]);
    end
  end

  assign ch3Reset = cntReset_ff && cmpEvt[CH_N-1];
  assign ovfEvt = tick && (cnt_ff == `FCC_CNT_MAX) && !ch3Reset;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= `FCC_CNT_RESET;
    end else if (wrCntHi) begin
      cnt_ff <= {busReq.wdata, cnt_ff[7:0]};
    end else if (wrCntLo) begin
      cnt_ff <= {cnt_ff[CNT_W-1:8], busReq.wdata};
    end else if (ch3Reset) begin
      cnt_ff <= `FCC_CNT_RESET;
    end else if (tick) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channels
  genvar g;
  generate
    for (g = 0; g < CH_N; g++) begin : gCh
      fcc_channel uCh (
        .clk(clk),
        .rst_n(rst_n),
        .pinIn(pinIn[g]),
        .edgeSel(fcc_edge_t'(edgeSel_ff[2*g+1:2*g])),
        .compareMode(compareMode_ff[g]),
        .action(fcc_action_t'(outAction_ff[2*g+1:2*g])),
        .toggleOnOvf(ovfToggle_ff[g]),
        .ovfEvt(ovfEvt),
        .cmpEvt(cmpEvt[g]),
        .captureEvt(capEvt[g]),
        .pinOut(pinOut[g]),
        .pinOe(pinOe[g])
      );
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CH_N; i++) begin
        value_ff[i] <= `FCC_CNT_RESET;
      end
    end else begin
      for (int i = 0; i < CH_N; i++) begin
        if (capEvt[i]) begin
          value_ff[i] <= cnt_ff;
        end else if (wrVal && (int'(valIdx) == i) && compareMode_ff[i]) begin
          if (valHigh) begin
            value_ff[i] <= {busReq.wdata, value_ff[i][7:0]};
          end else begin
            value_ff[i] <= {value_ff[i][CNT_W-1:8], busReq.wdata};
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flags, set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chFlag_ff <= '0;
    end else begin
      for (int i = 0; i < CH_N; i++) begin
        if (capEvt[i] || cmpEvt[i]) begin
          chFlag_ff[i] <= 1'b1;
        end else if (wrChFlg && busReq.wdata[i]) begin
          chFlag_ff[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovfFlag_ff <= 1'b0;
    end else if (ovfEvt) begin
      ovfFlag_ff <= 1'b1;
    end else if (wrOvFlg && busReq.wdata[`FCC_BIT_OVFLAG]) begin
      ovfFlag_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt requests and counter view
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chIrq <= '0;
    end else begin
      chIrq <= chFlag_ff & chIrqEn_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovfIrq <= 1'b0;
    end else begin
      ovfIrq <= ovfFlag_ff && ovfIrqEn_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timerCount <= `FCC_CNT_RESET;
    end else begin
      timerCount <= cnt_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port
  always_comb begin
    nxt_rdData = `FCC_REG_RESET;
    if (busReq.rd) begin
      unique case (busReq.addr)
        `FCC_OFS_MODE: nxt_rdData[CH_N-1:0] = compareMode_ff;
        `FCC_OFS_CNT_HI: nxt_rdData = cnt_ff[CNT_W-1:8];
        `FCC_OFS_CNT_LO: nxt_rdData = cnt_ff[7:0];
        `FCC_OFS_ENABLE: nxt_rdData[`FCC_BIT_ENABLE] = timerEnable_ff;
        `FCC_OFS_TOGGLE: nxt_rdData[CH_N-1:0] = ovfToggle_ff;
        `FCC_OFS_ACTION: nxt_rdData = outAction_ff;
        `FCC_OFS_EDGE: nxt_rdData = edgeSel_ff;
        `FCC_OFS_IRQEN: nxt_rdData[CH_N-1:0] = chIrqEn_ff;
        `FCC_OFS_SC2: begin
          nxt_rdData[`FCC_BIT_OVIRQ] = ovfIrqEn_ff;
          nxt_rdData[`FCC_BIT_CNTRST] = cntReset_ff;
          nxt_rdData[`FCC_PSC_MSB:`FCC_PSC_LSB] = pscSel_ff;
        end
        `FCC_OFS_CHFLG: nxt_rdData[CH_N-1:0] = chFlag_ff;
        `FCC_OFS_OVFLG: nxt_rdData[`FCC_BIT_OVFLAG] = ovfFlag_ff;
        default: begin
          if (busReq.addr >= `FCC_OFS_VAL_FIRST
              && busReq.addr <= `FCC_OFS_VAL_LAST) begin
            nxt_rdData = valHigh ? value_ff[valIdx][CNT_W-1:8]
                                 : value_ff[valIdx][7:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= `FCC_REG_RESET;
    end else begin
      rdData <= nxt_rdData;
    end
  end
endmodule

// ### tb/fcc_pin_model.sv
// Far-side pin model: external capture levels on the shared pins.
// Assumes one clock; the bench calls setLevel by hierarchical name.
`timescale 1ns/100ps
module fcc_pin_model (
  input wire logic clk,
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  output logic [3:0] pinIn
);
  logic [3:0] extLvl;
  initial extLvl = 4'h0;
  // Wire level, timer wins while it drives
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLvl);
  task automatic setLevel(input int ch, input logic lvl, input int hold);
    @(posedge clk);
    extLvl[ch] <= lvl;
    repeat (hold) @(posedge clk);
  endtask
endmodule

// ### tb/fcc_timer_asserts.sv
// Port checker for the timer, with shadows of written control bits.
// Assumes the plain register port and one clock.
`timescale 1ns/100ps
`include "fcc_params.svh"
module fcc_timer_asserts #(
  parameter int CH_N = 4,
  parameter int CNT_W = 16,
  parameter int PSC_W = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire fcc_pkg::fcc_bus_req_t busReq,
  input wire logic [`FCC_DATA_W-1:0] rdData,
  input wire logic [CH_N-1:0] pinIn,
  input wire logic [CH_N-1:0] pinOut,
  input wire logic [CH_N-1:0] pinOe,
  input wire logic [CH_N-1:0] chIrq,
  input wire logic ovfIrq,
  input wire logic [CNT_W-1:0] timerCount
);
  import fcc_pkg::*;
  logic ten_ff, oien_ff, cntWr;
  logic [3:0] tov_ff, ien_ff, oeExp;
  logic [7:0] act_ff;
  logic [2:0] hold_ff, step_ff;
  assign cntWr = busReq.wr && busReq.addr[7:1] == 7'h62;
  assign oeExp = {|act_ff[7:6], |act_ff[5:4], |act_ff[3:2], |act_ff[1:0]};
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {ten_ff, oien_ff, tov_ff, ien_ff, act_ff} <= '0;
    end else if (busReq.wr) begin
      case (busReq.addr)
        8'hc6: ten_ff <= busReq.wdata[7];
        8'hc7: tov_ff <= busReq.wdata[3:0];
        8'hc8: act_ff <= busReq.wdata;
        8'hca: ien_ff <= busReq.wdata[3:0];
        8'hcb: oien_ff <= busReq.wdata[7];
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_ff <= 3'h0;
      step_ff <= 3'h0;
    end else begin
      hold_ff <= {hold_ff[1:0], !ten_ff && !cntWr};
      step_ff <= {step_ff[1:0], !cntWr};
    end
  end
  ////////////////////////////////////////
  chk_rd_idle: assert property (!$past(busReq.rd) |-> rdData == 8'h00)
    else $error("read data not zero outside read cycle");
  chk_oe_action: assert property (
    busReq.wr && busReq.addr == 8'hc8 |-> ##2 pinOe == $past(oeExp))
    else $error("pin enable does not follow action field");
  chk_chirq_mask: assert property (
    (chIrq & ~$past(ien_ff)) == 4'h0)
    else $error("channel request while disabled");
  chk_ovf_mask: assert property (ovfIrq |-> $past(oien_ff))
    else $error("overflow request while disabled");
  chk_count_stop: assert property (
    &hold_ff |-> $stable(timerCount))
    else $error("counter moved while stopped");
  chk_count_step: assert property (
    &step_ff && $changed(timerCount) |->
    timerCount == $past(timerCount) + 1'b1 || timerCount == '0)
    else $error("counter step not plus one");
  chk_low_no_rise: assert property (
    act_ff[1:0] == 2'b10 && $past(act_ff[1:0]) == 2'b10 &&
    !tov_ff[0] && !$past(tov_ff[0]) |-> !$rose(pinOut[0]))
    else $error("low action pin rose");
  chk_high_no_fall: assert property (
    act_ff[7:6] == 2'b11 && $past(act_ff[7:6]) == 2'b11 &&
    !tov_ff[3] && !$past(tov_ff[3]) |-> !$fell(pinOut[3]))
    else $error("high action pin fell");
endmodule
bind fcc_timer fcc_timer_asserts #(.CH_N(CH_N), .CNT_W(CNT_W), .PSC_W(PSC_W))
  i_fcc_timer_asserts (.clk, .rst_n, .busReq, .rdData, .pinIn, .pinOut,
  .pinOe, .chIrq, .ovfIrq, .timerCount);

// ### tb/fcc_timer_tb.sv
// Bench for the timer: register tasks, pin model, sequences of checks.
// Assumes the design package and modules are compiled first.
`timescale 1ns/100ps
module fcc_timer_tb;
  import fcc_pkg::*;
  localparam logic [7:0] RA [5] = '{8'hc7, 8'hc8, 8'hc9, 8'hca, 8'hcb};
  localparam logic [7:0] RM [5] = '{8'h0f, 8'hff, 8'hff, 8'h0f, 8'h8f};
  logic clk, rst_n, ovfIrq, hit;
  fcc_bus_req_t busReq;
  logic [7:0] rdData, dLo;
  logic [3:0] pinIn, pinOut, pinOe, chIrq;
  logic [15:0] timerCount, c0;
  int errors, nChecks;
  fcc_timer i_fcc_timer (.clk, .rst_n, .busReq, .rdData, .pinIn, .pinOut,
    .pinOe, .chIrq, .ovfIrq, .timerCount);
  fcc_pin_model i_fcc_pin_model (.clk, .pinOut, .pinOe, .pinIn);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] want, seen);
    nChecks++;
    if (seen !== want) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrReg(input logic [7:0] a, d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask
  task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    busReq.addr <= a;
    busReq.rd <= 1'b1;
    @(posedge clk);
    busReq.rd <= 1'b0;
    @(posedge clk);
    d = rdData;
  endtask
  task automatic rdChk(input logic [7:0] a, want);
    logic [7:0] d;
    rdReg(a, d);
    check($sformatf("reg %h", a), {8'h0, want}, {8'h0, d});
  endtask
  task automatic doReset();
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end
  ////////////////////////////////////////
  initial begin
    errors = 0;
    nChecks = 0;
    rst_n = 1'b0;
    busReq = '0;
    doReset();
    for (int i = 0; i < 5; i++) begin
      rdChk(RA[i], 8'h00);
      wrReg(RA[i], 8'hff);
      rdChk(RA[i], RM[i]);
      wrReg(RA[i], 8'h00);
    end
    wrReg(8'hf0, 8'h5a);
    rdChk(8'hf0, 8'h00);
    // Prescaler ratios, then stop
    wrReg(8'hc6, 8'h80);
    for (int p = 0; p < 8; p++) begin
      wrReg(8'hcb, 8'(p));
      cyc(300);
      c0 = timerCount;
      cyc(512);
      check("prescale", 16'(512 >> p), timerCount - c0);
    end
    wrReg(8'hc6, 8'h00);
    cyc(4);
    c0 = timerCount;
    cyc(200);
    check("stopped", c0, timerCount);
    // Channel 3 compare actions with counter reset
    wrReg(8'hc0, 8'h08);
    wrReg(8'hc4, 8'h00);
    wrReg(8'hc5, 8'h00);
    wrReg(8'hd5, 8'h10);
    wrReg(8'hcb, 8'h08);
    wrReg(8'hc6, 8'h80);
    for (int a = 0; a < 4; a++) begin
      wrReg(8'hc8, 8'(a << 6));
      cyc(60);
      check("oe", 16'(a != 0), 16'(pinOe[3]));
      check("bound", 16'h1, 16'(timerCount <= 16'h10));
      c0 = 16'(pinOut[3]);
      cyc(17);
      if (a == 1) check("toggle", ~c0 & 16'h1, 16'(pinOut[3]));
      if (a >= 2) check("level", 16'(a - 2), 16'(pinOut[3]));
    end
    rdChk(8'hcc, 8'h08);
    wrReg(8'hd5, 8'h00);
    wrReg(8'hc5, 8'h00);
    cyc(50);
    check("held", 16'h0, timerCount);
    // Capture edges on channel 2
    wrReg(8'hcb, 8'h00);
    for (int e = 0; e < 4; e++) begin
      wrReg(8'hc9, 8'(e << 4));
      wrReg(8'hca, {5'h0, e[0], 2'h0});
      for (int lv = 1; lv >= 0; lv--) begin
        wrReg(8'hcc, 8'h0f);
        c0 = timerCount;
        i_fcc_pin_model.setLevel(2, lv[0], 8);
        hit = (lv == 1) ? e[0] : e[1];
        rdChk(8'hcc, {5'h0, hit, 2'h0});
        check("irq", 16'(hit & e[0]), 16'(chIrq[2]));
        rdReg(8'hd3, dLo);
        if (hit) check("capt", 16'h1, 16'(8'(dLo - c0[7:0]) < 8'd10));
      end
    end
    wrReg(8'hcc, 8'h00);
    rdChk(8'hcc, 8'h04);
    // Overflow toggle, flag, request and mask
    doReset();
    wrReg(8'hc0, 8'h01);
    wrReg(8'hce, 8'hff);
    wrReg(8'hcf, 8'hff);
    wrReg(8'hc8, 8'h0a);
    wrReg(8'hc7, 8'h03);
    wrReg(8'hcb, 8'h80);
    for (int w = 0; w < 2; w++) begin
      wrReg(8'hc4, 8'hff);
      wrReg(8'hc5, 8'hf0);
      wrReg(8'hc6, 8'h80);
      cyc(40);
      check("ovfirq", 16'(1 - w), 16'(ovfIrq));
      check("tog", 16'(1 - w), 16'(pinOut[0]));
      check("cappin", 16'h0, 16'(pinOut[1]));
      rdChk(8'hcd, 8'h80);
      wrReg(8'hcd, 8'h80);
      rdChk(8'hcd, 8'h00);
      wrReg(8'hcb, 8'h00);
    end
    wrReg(8'hc0, 8'h09);
    wrReg(8'hd4, 8'hff);
    wrReg(8'hd5, 8'hff);
    wrReg(8'hcb, 8'h08);
    wrReg(8'hc4, 8'hff);
    wrReg(8'hc5, 8'hf0);
    cyc(40);
    rdChk(8'hcd, 8'h00);
    end_of_test();
  end
endmodule
